//--- src/pfs_consts.svh
`ifndef PFS_CONSTS_SVH
`define PFS_CONSTS_SVH
// ----------------------------------------
// Parameter numbers
// ----------------------------------------
`define PFS_P_BEARING_LIMIT 10'h084
`define PFS_P_MOTOR_LIMIT   10'h085
`define PFS_P_ERR_HIST      10'h0ab
`define PFS_P_ERR_HOURS     10'h0b0
`define PFS_P_REPLY_DELAY   10'h0b4
`define PFS_P_PASS_TIME     10'h0b7
`define PFS_P_DRIVE_HOURS   10'h0b8
`define PFS_P_STATE_WORD    10'h12f
`define PFS_P_CATALOG       10'h138
`define PFS_P_SERIAL        10'h13b
`define PFS_P_HW_VERSION    10'h13c
// ----------------------------------------
// Reset values and limits
// ----------------------------------------
`define PFS_BEARING_LIMIT_RST 16'h0050
`define PFS_MOTOR_LIMIT_RST   16'h0064
`define PFS_REPLY_DELAY_RST   16'h000a
`define PFS_REPLY_DELAY_MIN   16'h0002
`define PFS_REPLY_DELAY_MAX   16'h0013
`define PFS_PASS_TIME_RST     16'h01f4
`define PFS_CONV_TEMP_LIMIT   16'h004b
`define PFS_CRIT_FREQ_LOW     16'h003c
`define PFS_OVERSPEED_NUM     32'h0000000b
`define PFS_OVERSPEED_DEN     32'h0000000a
`define PFS_PERCENT_FULL      32'h00000064
`define PFS_SERIAL_MASK       32'h000001ff
// ----------------------------------------
// Error codes
// ----------------------------------------
`define PFS_ERR_NONE      4'h0
`define PFS_ERR_OVERSPEED 4'h1
`define PFS_ERR_PASS      4'h2
`define PFS_ERR_BEARING   4'h3
`define PFS_ERR_SHORT     4'h4
`define PFS_ERR_CONV      4'h5
`define PFS_ERR_RUNUP     4'h6
`define PFS_ERR_MOTOR     4'h7
`define PFS_ERR_PUMP      4'h8
// ----------------------------------------
// Timing
// ----------------------------------------
`define PFS_CLK_NS            100
`define PFS_MS_NS             1000000
`define PFS_MS_PER_S          1000
`define PFS_S_PER_HUNDREDTH_H 36
`define PFS_HIST_DEPTH        8
`endif

//--- src/pfs_pkg.sv
package pfs_pkg;
    typedef struct packed {
        logic        wr;
        logic [9:0]  num;
        logic [2:0]  idx;
        logic [31:0] wdata;
    } pfs_req_s;

    typedef struct packed {
        logic        ok;
        logic [31:0] data;
    } pfs_rsp_s;

    typedef enum logic [1:0] {
        PFS_IDLE = 2'b01,
        PFS_WAIT = 2'b10
    } pfs_state_e;
endpackage

//--- src/pfs_top.sv
`timescale 1ns/1ps
`include "pfs_consts.svh"
// Overview of operation
// - Either bearing reading above limit stops drive and logs code 3.
// - Motor coil temperature above limit stops drive and logs code 7.
// - Eight-deep code history, newest in slot 0, oldest kept in slot 7.
// - Matching eight-deep 32-bit hour stamps in 0.01 h units.
// - Reply waits the programmable delay in ms, default 10 ms.
// - Code 2 if 60 Hz < frequency < minimum after passing time.
// - Frequency above nominal by more than 10 percent gives code 1.
// - Converter temperature above 75 C gives code 5.
// - Code 6 if below normal level when run-up time expires.
// - Motor or cable short circuit gives code 4.
// - Missing or unknown pump gives code 8; code 0 means none.
// - 32-bit hours total in 0.01 h, counting only while driving.
// - State word bits: normal, ready, accelerating, decelerating.
// - Any active error forces state word to zero.
// - Serial number reads as 32 bits holding nine low bits.
// - Read-only 16-bit hardware version index 0 to 100.
// - Normal when frequency at least setpoint times percent.
// - Any failure shuts drive down and lights fault indicator.
module pfs_top #(
    parameter int          MS_CYCLES     = `PFS_MS_NS / `PFS_CLK_NS,
    parameter int          MS_PER_S      = `PFS_MS_PER_S,
    parameter int          S_PER_TICK    = `PFS_S_PER_HUNDREDTH_H,
    // Arbitrary identity values
    parameter logic [31:0] SERIAL_NUMBER = 32'h00000123,
    parameter logic [15:0] CATALOG_CODE  = 16'h0abc,
    parameter logic [15:0] HW_VERSION    = 16'h0001
) (
    input  wire  logic              core_clk,
    input  wire  logic              rst_n,
    input  wire  logic              start_cmd,
    input  wire  logic [15:0]       bearing_temp_reading_a,
    input  wire  logic [15:0]       bearing_temp_reading_b,
    input  wire  logic [15:0]       motor_coil_temp,
    input  wire  logic [15:0]       converter_temp,
    input  wire  logic [15:0]       rotor_frequency,
    input  wire  logic [15:0]       min_frequency_level,
    input  wire  logic [15:0]       nominal_frequency,
    input  wire  logic [15:0]       setpoint_frequency,
    input  wire  logic [15:0]       normal_level_percent,
    input  wire  logic [15:0]       run_up_time_limit,
    input  wire  logic              short_detect,
    input  wire  logic              pump_absent,
    input  wire  logic              req_valid,
    input  wire  pfs_pkg::pfs_req_s req,
    output logic                    req_ready,
    output logic                    rsp_valid,
    output pfs_pkg::pfs_rsp_s       rsp,
    output logic                    drive_on,
    output logic                    fault_led,
    output logic [3:0]              fault_code,
    output logic [15:0]             state_word
);
    import pfs_pkg::*;

    // ----------------------------------------
    // State
    // ----------------------------------------
    localparam int HD = `PFS_HIST_DEPTH;
    logic [31:0] ms_cnt_q, ms_cnt_d, s_cnt_q, s_cnt_d, hx_cnt_q, hx_cnt_d;
    logic [31:0] hours_q, hours_d;
    logic [15:0] pass_s_q, pass_s_d, run_s_q, run_s_d;
    logic [15:0] delay_q, delay_d, dly_cnt_q, dly_cnt_d, prev_f_q;
    logic [3:0]  hist_q [HD], hist_d [HD];
    logic [31:0] hstamp_q [HD], hstamp_d [HD];
    logic        fault_q, fault_d, drive_d, rsp_valid_d;
    logic [3:0]  code_q, code_d;
    logic [15:0] sw_d;
    pfs_state_e  st_q, st_d;
    pfs_req_s    rq_q, rq_d;
    pfs_rsp_s    rsp_d;
    logic [8:1]  cond;
    logic        ms_tick, s_tick, h_tick, normal, new_fault;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [3:0] first_code(input logic [8:1] c);
        first_code = `PFS_ERR_NONE;
        for (int i = 8; i >= 1; i--) begin
            if (c[i]) begin
                first_code = 4'(i);
            end
        end
    endfunction

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        ms_tick = ms_cnt_q == 32'(MS_CYCLES - 1);
        s_tick = ms_tick && (s_cnt_q == 32'(MS_PER_S - 1));
        h_tick = s_tick && drive_on && (hx_cnt_q == 32'(S_PER_TICK - 1));
        ms_cnt_d = ms_tick ? 32'h0 : ms_cnt_q + 32'h1;
        s_cnt_d = s_cnt_q;
        if (ms_tick) begin
            s_cnt_d = s_tick ? 32'h0 : s_cnt_q + 32'h1;
        end
        hx_cnt_d = hx_cnt_q;
        if (s_tick && drive_on) begin
            hx_cnt_d = h_tick ? 32'h0 : hx_cnt_q + 32'h1;
        end
        hours_d = h_tick ? hours_q + 32'h1 : hours_q;
        pass_s_d = 16'h0;
        run_s_d = 16'h0;
        if (start_cmd) begin
            pass_s_d = (s_tick && pass_s_q != 16'hffff) ?
                       pass_s_q + 16'h1 : pass_s_q;
            run_s_d = (s_tick && run_s_q != 16'hffff) ?
                      run_s_q + 16'h1 : run_s_q;
        end
        normal = 32'(rotor_frequency) * `PFS_PERCENT_FULL >=
                 32'(setpoint_frequency) * 32'(normal_level_percent);
        cond[1] = 32'(rotor_frequency) * `PFS_OVERSPEED_DEN >
                  32'(nominal_frequency) * `PFS_OVERSPEED_NUM;
        cond[2] = start_cmd && pass_s_q >= `PFS_PASS_TIME_RST &&
                  rotor_frequency > `PFS_CRIT_FREQ_LOW &&
                  rotor_frequency < min_frequency_level;
        cond[3] = bearing_temp_reading_a > `PFS_BEARING_LIMIT_RST ||
                  bearing_temp_reading_b > `PFS_BEARING_LIMIT_RST;
        cond[4] = short_detect;
        cond[5] = converter_temp > `PFS_CONV_TEMP_LIMIT;
        cond[6] = start_cmd && run_s_q >= run_up_time_limit && !normal;
        cond[7] = motor_coil_temp > `PFS_MOTOR_LIMIT_RST;
        cond[8] = pump_absent;
        new_fault = !fault_q && (|cond);
        fault_d = fault_q;
        code_d = code_q;
        if (new_fault) begin
            fault_d = 1'b1;
            code_d = first_code(cond);
        end else if (fault_q && !start_cmd && !(|cond)) begin
            fault_d = 1'b0;
            code_d = `PFS_ERR_NONE;
        end
        drive_d = start_cmd && !fault_d;
        for (int i = 0; i < HD; i++) begin
            hist_d[i] = hist_q[i];
            hstamp_d[i] = hstamp_q[i];
        end
        if (new_fault) begin
            hist_d[0] = first_code(cond);
            hstamp_d[0] = hours_q;
            for (int i = 1; i < HD; i++) begin
                hist_d[i] = hist_q[i - 1];
                hstamp_d[i] = hstamp_q[i - 1];
            end
        end
        sw_d = {12'h000, rotor_frequency < prev_f_q,
                rotor_frequency > prev_f_q, 1'b1, normal && drive_d};
        if (fault_d) begin
            sw_d = 16'h0000;
        end
        st_d = st_q;
        rq_d = rq_q;
        delay_d = delay_q;
        dly_cnt_d = dly_cnt_q;
        rsp_valid_d = 1'b0;
        rsp_d = rsp;
        unique case (st_q)
            PFS_IDLE: begin
                if (req_valid && req_ready) begin
                    rq_d = req;
                    dly_cnt_d = 16'h0;
                    st_d = PFS_WAIT;
                    if (req.wr && req.num == `PFS_P_REPLY_DELAY &&
                        req.wdata[15:0] >= `PFS_REPLY_DELAY_MIN &&
                        req.wdata[15:0] <= `PFS_REPLY_DELAY_MAX) begin
                        delay_d = req.wdata[15:0];
                    end
                end
            end
            PFS_WAIT: begin
                if (dly_cnt_q > delay_q) begin
                    st_d = PFS_IDLE;
                    rsp_valid_d = 1'b1;
                    rsp_d.ok = !rq_q.wr;
                    rsp_d.data = 32'h0;
                    unique case (rq_q.num)
                        `PFS_P_BEARING_LIMIT:
                            rsp_d.data = 32'(`PFS_BEARING_LIMIT_RST);
                        `PFS_P_MOTOR_LIMIT:
                            rsp_d.data = 32'(`PFS_MOTOR_LIMIT_RST);
                        `PFS_P_ERR_HIST: rsp_d.data = 32'(hist_q[rq_q.idx]);
                        `PFS_P_ERR_HOURS: rsp_d.data = hstamp_q[rq_q.idx];
                        `PFS_P_REPLY_DELAY: begin
                            rsp_d.data = 32'(delay_q);
                            rsp_d.ok = !rq_q.wr || delay_q ==
                                       rq_q.wdata[15:0];
                        end
                        `PFS_P_PASS_TIME:
                            rsp_d.data = 32'(`PFS_PASS_TIME_RST);
                        `PFS_P_DRIVE_HOURS: rsp_d.data = hours_q;
                        `PFS_P_STATE_WORD: rsp_d.data = 32'(state_word);
                        `PFS_P_CATALOG: rsp_d.data = 32'(CATALOG_CODE);
                        `PFS_P_SERIAL:
                            rsp_d.data = SERIAL_NUMBER & `PFS_SERIAL_MASK;
                        `PFS_P_HW_VERSION: rsp_d.data = 32'(HW_VERSION);
                        default: rsp_d.ok = 1'b0;
                    endcase
                end else if (ms_tick) begin
                    dly_cnt_d = dly_cnt_q + 16'h1;
                end
            end
            default: st_d = PFS_IDLE;
        endcase
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            ms_cnt_q <= 32'h0;
            s_cnt_q <= 32'h0;
            hx_cnt_q <= 32'h0;
            hours_q <= 32'h0;
            pass_s_q <= 16'h0;
            run_s_q <= 16'h0;
            delay_q <= `PFS_REPLY_DELAY_RST;
            dly_cnt_q <= 16'h0;
            prev_f_q <= 16'h0;
            for (int i = 0; i < HD; i++) begin
                hist_q[i] <= `PFS_ERR_NONE;
                hstamp_q[i] <= 32'h0;
            end
            fault_q <= 1'b0;
            code_q <= `PFS_ERR_NONE;
            st_q <= PFS_IDLE;
            rq_q <= '0;
            req_ready <= 1'b0;
            rsp_valid <= 1'b0;
            rsp <= '0;
            drive_on <= 1'b0;
            fault_led <= 1'b0;
            fault_code <= `PFS_ERR_NONE;
            state_word <= 16'h0000;
        end else begin
            ms_cnt_q <= ms_cnt_d;
            s_cnt_q <= s_cnt_d;
            hx_cnt_q <= hx_cnt_d;
            hours_q <= hours_d;
            pass_s_q <= pass_s_d;
            run_s_q <= run_s_d;
            delay_q <= delay_d;
            dly_cnt_q <= dly_cnt_d;
            prev_f_q <= rotor_frequency;
            hist_q <= hist_d;
            hstamp_q <= hstamp_d;
            fault_q <= fault_d;
            code_q <= code_d;
            st_q <= st_d;
            rq_q <= rq_d;
            req_ready <= st_d == PFS_IDLE;
            rsp_valid <= rsp_valid_d;
            rsp <= rsp_d;
            drive_on <= drive_d;
            fault_led <= fault_d;
            fault_code <= code_d;
            state_word <= sw_d;
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    AST_BEARING_CODE: assert property (
        !fault_q && cond == 8'b00000100 |=> fault_code == 4'h3 && !drive_on)
        else $error("Bearing fault not coded 3");
    AST_MOTOR_CODE: assert property (
        !fault_q && cond == 8'b01000000 |=> fault_code == 4'h7)
        else $error("Motor fault not coded 7");
    AST_HIST_SHIFT: assert property (
        new_fault |=> hist_q[7] == $past(hist_q[6]) &&
                      hist_q[1] == $past(hist_q[0]))
        else $error("Code history did not shift");
    AST_STAMP_PAIR: assert property (
        new_fault |=> hstamp_q[0] == $past(hours_q) &&
                      hist_q[0] == fault_code)
        else $error("Stamp and code not paired");
    AST_REPLY_LATE: assert property (
        st_q == PFS_WAIT && dly_cnt_q <= delay_q |-> !rsp_valid_d)
        else $error("Reply before delay");
    AST_SW_ZERO: assert property (
        fault_q |-> state_word == 16'h0000)
        else $error("State word not zero on fault");
    AST_DRIVE_OFF: assert property (
        |cond |=> !drive_on && fault_led)
        else $error("Drive on during failure");
    AST_HOURS_IDLE: assert property (
        !drive_on |=> hours_q == $past(hours_q))
        else $error("Hours counted with drive off");
    AST_OVERSPEED: assert property (
        !fault_q && cond == 8'b00000001 |=> fault_code == 4'h1)
        else $error("Overspeed not coded 1");
    AST_DELAY_REPLY: assert property (
        st_q == PFS_IDLE && req_valid && req_ready |=>
        (st_q == PFS_WAIT) [*2] ##0 !rsp_valid)
        else $error("Request not held waiting");
    COV_FAULT: cover property (new_fault ##1 fault_led);
    COV_REPLY: cover property (req_valid ##[1:300] rsp_valid);
    COV_CLEAR: cover property (fault_q ##1 !fault_q);
endmodule

//--- tb/pfs_host.sv
`timescale 1ns/1ps
// ----------------------------------------
// Host side of the parameter port
// ----------------------------------------
module pfs_host (
    input  wire logic              core_clk,
    input  wire logic              req_ready,
    input  wire logic              rsp_valid,
    input  wire pfs_pkg::pfs_rsp_s rsp,
    output logic                   req_valid,
    output pfs_pkg::pfs_req_s      req
);
    import pfs_pkg::*;

    initial begin
        req_valid = 1'b0;
        req = '0;
    end

    task automatic xfer(input pfs_req_s c, output pfs_rsp_s r, output int n);
        n = 0;
        @(negedge core_clk);
        req_valid = 1'b1;
        req = c;
        do @(posedge core_clk); while (req_ready !== 1'b1);
        @(negedge core_clk);
        req_valid = 1'b0;
        req = ~c;
        do begin
            @(posedge core_clk);
            n++;
        end while (rsp_valid !== 1'b1 && n < 5000);
        r = rsp;
    endtask
endmodule

//--- tb/pfs_top_test.sv
`timescale 1ns/1ps
module pfs_top_test;
    import pfs_pkg::*;
    // ----------------------------------------
    // Scaled timing and identity
    // ----------------------------------------
    localparam int          MSC = 10;
    localparam int          SEC = 40;
    localparam int          TICK = 80;
    localparam logic [31:0] SERIAL = 32'h00000123; // Arbitrary value
    localparam logic [15:0] CATALOG = 16'h0abc;    // Arbitrary value
    localparam logic [15:0] HW_VER = 16'h0001;     // Arbitrary value
    localparam logic [9:0]  RD_NUM [9] = '{10'h084, 10'h085, 10'h0b4,
        10'h0b7, 10'h0ab, 10'h13b, 10'h138, 10'h13c, 10'h3ff};
    localparam logic [31:0] RD_EXP [9] = '{32'h50, 32'h64, 32'ha, 32'h1f4,
        32'h0, SERIAL & 32'h1ff, 32'(CATALOG), 32'(HW_VER), 32'h0};
    localparam logic        RD_OK [9] = '{1, 1, 1, 1, 1, 1, 1, 1, 0};
    localparam logic [9:0]  WR_NUM [4] = '{10'h084, 10'h0b4, 10'h0b4, 10'h0b4};
    localparam logic [31:0] WR_DAT [4] = '{32'h51, 32'h14, 32'h1, 32'h2};
    localparam logic        WR_OK [4] = '{0, 0, 0, 1};
    localparam logic [3:0]  TRIP_CODE [8] = '{4'h1, 4'h3, 4'h3, 4'h4,
        4'h5, 4'h7, 4'h8, 4'h3};

    logic        core_clk;
    logic        rst_n;
    logic        start_cmd;
    logic [15:0] bearing_temp_reading_a;
    logic [15:0] bearing_temp_reading_b;
    logic [15:0] motor_coil_temp;
    logic [15:0] converter_temp;
    logic [15:0] rotor_frequency;
    logic [15:0] min_frequency_level;
    logic [15:0] nominal_frequency;
    logic [15:0] setpoint_frequency;
    logic [15:0] normal_level_percent;
    logic [15:0] run_up_time_limit;
    logic        short_detect;
    logic        pump_absent;
    logic        req_valid;
    pfs_req_s    req;
    logic        req_ready;
    logic        rsp_valid;
    pfs_rsp_s    rsp;
    logic        drive_on;
    logic        fault_led;
    logic [3:0]  fault_code;
    logic [15:0] state_word;
    int          errors;
    int          checks;
    int          cyc;
    int          hist_q[$];
    pfs_rsp_s    r;
    int          n;
    logic [31:0] h0;
    int          c0;

    pfs_top #(.MS_CYCLES(MSC), .MS_PER_S(4), .S_PER_TICK(2),
        .SERIAL_NUMBER(SERIAL), .CATALOG_CODE(CATALOG), .HW_VERSION(HW_VER))
    pfs_top_inst (.core_clk, .rst_n, .start_cmd, .bearing_temp_reading_a,
        .bearing_temp_reading_b, .motor_coil_temp, .converter_temp,
        .rotor_frequency, .min_frequency_level, .nominal_frequency,
        .setpoint_frequency, .normal_level_percent, .run_up_time_limit,
        .short_detect, .pump_absent, .req_valid, .req, .req_ready,
        .rsp_valid, .rsp, .drive_on, .fault_led, .fault_code, .state_word);

    pfs_host pfs_host_inst (.core_clk, .req_ready, .rsp_valid, .rsp,
        .req_valid, .req);

    // ----------------------------------------
    // Clock, timeout and checking
    // ----------------------------------------
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    always @(posedge core_clk) begin
        cyc = cyc + 1;
        if (cyc == 30000) begin
            errors = errors + 1;
            wrap_up();
        end
    end

    task automatic wrap_up();
        $display("checks=%0d errors=%0d", checks, errors);
        if (errors == 0 && checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic xfer(input logic wr, input logic [9:0] num,
                        input logic [2:0] idx, input logic [31:0] wd);
        pfs_host_inst.xfer('{wr: wr, num: num, idx: idx, wdata: wd}, r, n);
        chk(32'(n < 5000), 32'h1);
    endtask

    // ----------------------------------------
    // Stimulus helpers
    // ----------------------------------------
    task automatic calm();
        @(negedge core_clk);
        bearing_temp_reading_a = 16'($urandom_range(80));
        bearing_temp_reading_b = 16'($urandom_range(80));
        motor_coil_temp = 16'($urandom_range(100));
        converter_temp = 16'($urandom_range(75));
        rotor_frequency = 16'd860;
        short_detect = 1'b0;
        pump_absent = 1'b0;
    endtask

    task automatic release_fault();
        calm();
        start_cmd = 1'b0;
        repeat (2) @(negedge core_clk);
        chk(fault_led, 1'b0);
        start_cmd = 1'b1;
        repeat (3) @(negedge core_clk);
    endtask

    task automatic hit(input logic [3:0] code);
        chk(fault_code, code);
        chk(drive_on, 1'b0);
        chk(fault_led, 1'b1);
        chk(state_word, 16'h0000);
        hist_q.push_front(int'(code));
        hist_q = hist_q[0:7];
    endtask

    task automatic wait_fault(input int lim);
        for (int i = 0; i < lim && fault_led !== 1'b1; i++) @(negedge core_clk);
    endtask

    task automatic trip(input int k);
        @(negedge core_clk);
        chk(drive_on, 1'b1);
        chk(state_word, 16'h0003);
        case (k)
            0: rotor_frequency = 16'd947;
            1: bearing_temp_reading_a = 16'd81;
            2: bearing_temp_reading_b = 16'd81;
            3: short_detect = 1'b1;
            4: converter_temp = 16'd76;
            5: motor_coil_temp = 16'd101;
            6: pump_absent = 1'b1;
            default: begin
                bearing_temp_reading_b = 16'd90;
                motor_coil_temp = 16'd120;
            end
        endcase
        @(negedge core_clk);
        hit(TRIP_CODE[k]);
        pump_absent = 1'b1;
        repeat (2) @(negedge core_clk);
        chk(fault_code, TRIP_CODE[k]);
        release_fault();
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        void'($urandom(32'h5fa3));
        rst_n = 1'b0;
        start_cmd = 1'b0;
        {bearing_temp_reading_a, bearing_temp_reading_b} = '0;
        {motor_coil_temp, converter_temp, rotor_frequency} = '0;
        {short_detect, pump_absent} = 2'b00;
        min_frequency_level = 16'd450;
        nominal_frequency = 16'd860;
        setpoint_frequency = 16'd860;
        normal_level_percent = 16'd90;
        run_up_time_limit = 16'hffff;
        hist_q = '{0, 0, 0, 0, 0, 0, 0, 0};
        repeat (12) @(negedge core_clk);
        rst_n = 1'b1;
        for (int i = 0; i < 9; i++) begin
            xfer(1'b0, RD_NUM[i], 3'd0, 32'h0);
            chk(r.ok, RD_OK[i]);
            chk(r.data, RD_EXP[i]);
        end
        chk(n >= 10 * MSC && n <= 11 * MSC + 3, 1'b1);
        for (int i = 0; i < 4; i++) begin
            xfer(1'b1, WR_NUM[i], 3'd0, WR_DAT[i]);
            chk(r.ok, WR_OK[i]);
        end
        xfer(1'b0, 10'h0b4, 3'd0, 32'h0);
        chk(r.data, 32'h2);
        chk(n >= 2 * MSC && n <= 3 * MSC + 3, 1'b1);
        calm();
        start_cmd = 1'b1;
        repeat (3) @(negedge core_clk);
        chk(state_word, 16'h0003);
        repeat (3) @(negedge core_clk) rotor_frequency++;
        chk(state_word, 16'h0007);
        repeat (3) @(negedge core_clk) rotor_frequency--;
        chk(state_word, 16'h000b);
        rotor_frequency = 16'd700;
        repeat (3) @(negedge core_clk);
        chk(state_word, 16'h0002);
        calm();
        repeat (3) @(negedge core_clk);
        xfer(1'b0, 10'h12f, 3'd0, 32'h0);
        chk(r.data, 32'h3);
        xfer(1'b0, 10'h0b8, 3'd0, 32'h0);
        h0 = r.data;
        c0 = cyc;
        repeat (10 * TICK) @(posedge core_clk);
        xfer(1'b0, 10'h0b8, 3'd0, 32'h0);
        n = (cyc - c0) / TICK;
        chk(r.data - h0 >= n - 1 && r.data - h0 <= n + 1, 1'b1);
        h0 = r.data;
        trip(0);
        xfer(1'b0, 10'h0b0, 3'd0, 32'h0);
        chk(r.data - h0 <= 1, 1'b1);
        for (int k = 1; k < 8; k++) trip(k);
        start_cmd = 1'b0;
        run_up_time_limit = 16'd3;
        rotor_frequency = 16'd500;
        @(negedge core_clk);
        start_cmd = 1'b1;
        repeat (2 * SEC) @(negedge core_clk);
        chk(fault_led, 1'b0);
        wait_fault(3 * SEC);
        hit(4'h6);
        run_up_time_limit = 16'hffff;
        release_fault();
        start_cmd = 1'b0;
        rotor_frequency = 16'd200;
        @(negedge core_clk);
        start_cmd = 1'b1;
        repeat (499 * SEC) @(negedge core_clk);
        chk(fault_led, 1'b0);
        wait_fault(3 * SEC);
        hit(4'h2);
        release_fault();
        h0 = 32'hffffffff;
        for (int i = 0; i < 8; i++) begin
            xfer(1'b0, 10'h0ab, 3'(i), 32'h0);
            chk(r.data, 32'(hist_q[i]));
            xfer(1'b0, 10'h0b0, 3'(i), 32'h0);
            chk(32'(r.data <= h0), 32'h1);
            h0 = r.data;
        end
        wrap_up();
    end
endmodule
